// ### include/wdu_pkg.sv
// constants and carrier types for the watchdog timer unit
// assumes a 20 MHz system clock and a 32-bit classic wishbone register bus
//
// Notes on behaviour
// - out of reset, an overflow requests a hardware reset
// - overflow action may go to interrupt once; later writes of one ignored
// - watchdog leaves reset enabled and counting without any write
// - overflow with action bit one raises a reset request
// - overflow with action bit zero raises the watchdog interrupt
// - stop, idle and sleep modes hold the count; it resumes afterwards
// - divider feeds a two-stage binary counter; clear code zeroes only the latter
// - two-bit field picks 2^25..2^19 fast or 2^17..2^11 slow periods
// - enable bit one enables; zero only prepares a disable
// - disable code acts only while the enable bit is already zero
// - config register is write-only; software avoids read-modify-write
// - with interrupt action, repeated overflows give a periodic interrupt
// - while disabled the binary counter stages are held cleared
// - watchdog interrupt is non-maskable and never gated here
package wdu_pkg;

    // register word indices; byte address is four times the index
    localparam logic [7:0] WDU_CFG_IDX = 8'h34;
    localparam logic [7:0] WDU_CMD_IDX = 8'h35;
    localparam logic [7:0] WDU_STAT_IDX = 8'h36;
    localparam int WDU_ADR_W = 10;

    // command codes
    localparam logic [7:0] WDU_CMD_CLEAR = 8'h4E;
    localparam logic [7:0] WDU_CMD_DISABLE = 8'hB1;
    localparam logic [7:0] WDU_CMD_TRAP = 8'hD2;

    // configuration fields, bit 5 downward
    typedef struct packed {
        logic ram_trap_enable;
        logic trap_action_sel;
        logic wd_enable_bit;
        logic [1:0] detect_time_sel;
        logic overflow_action_sel;
    } wdu_cfg_t;
    localparam int WDU_CFG_W = 6;
    localparam wdu_cfg_t WDU_CFG_RESET = 6'h39;

    // operating mode levels from the system controller
    typedef struct packed {
        logic stop_mode;
        logic idle_mode;
        logic sleep_mode;
        logic slow_mode;
        logic divider_clock_sel;
    } wdu_mode_t;

    // status word
    typedef struct packed {
        logic [1:0] bin_count;
        logic halted;
        logic low_clock;
        logic trap_area_en;
        logic active;
        wdu_cfg_t cfg;
    } wdu_stat_t;
    localparam int WDU_STAT_W = 12;

    // period exponents and counter geometry
    localparam logic [4:0] WDU_FC_EXP0 = 5'h19;
    localparam logic [4:0] WDU_FS_EXP0 = 5'h11;
    localparam logic [4:0] WDU_EXP_STEP = 5'h02;
    localparam logic [4:0] WDU_TAP_OFS = 5'h03;
    localparam int WDU_DIV_W = 23;
    localparam int WDU_BIN_W = 2;

endpackage : wdu_pkg

// ### hdl/wdu_sync.sv
// two flip-flop level synchroniser
// assumes d_i is asynchronous to clk_i
`timescale 1ns/1ps
`default_nettype none
module wdu_sync (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic d_i,
    output logic q_o
);
    logic meta_r;

    // first stage feeds only the second
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_r <= 1'b0;
            q_o <= 1'b0;
        end else begin
            meta_r <= d_i;
            q_o <= meta_r;
        end
    end
endmodule : wdu_sync
`default_nettype wire

// ### hdl/wdu_counter.sv
// prescaling divider and two-stage binary counter
// assumes tick_i is a one-cycle count strobe and tap_i is below the divider width
`timescale 1ns/1ps
`default_nettype none
module wdu_counter
    import wdu_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tick_i,
    input wire logic clear_i,
    input wire logic run_i,
    input wire logic [4:0] tap_i,
    output logic ovf_o,
    output logic [WDU_BIN_W-1:0] bin_o
);
    logic [WDU_DIV_W-1:0] div_r;
    logic [WDU_DIV_W-1:0] mask;
    logic carry;

    // low tap+1 bits all ones means the tap bit carries on this tick
    always_comb begin
        for (int i = 0; i < WDU_DIV_W; i++) begin
            mask[i] = (5'(i) <= tap_i);
        end
        carry = tick_i && (&(div_r | ~mask));
        ovf_o = run_i && carry && !clear_i && (&bin_o);
    end

    // divider is cleared only by reset, so a clear can leave up to a quarter done
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_r <= '0;
        end else if (tick_i) begin
            div_r <= div_r + 1'b1;
        end
    end

    // binary stages: cleared by command or while disabled
    always_ff @(posedge clk_i) begin
        if (rst_i || !run_i || clear_i) begin
            bin_o <= '0;
        end else if (carry) begin
            bin_o <= bin_o + 1'b1;
        end
    end
endmodule : wdu_counter
`default_nettype wire

// ### hdl/wdu_top.sv
// watchdog timer unit: wishbone registers, clock choice, overflow action
// assumes mode_i comes from logic on clk_i and fs_clk_i is an external slow clock pin
`timescale 1ns/1ps
`default_nettype none
module wdu_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [wdu_pkg::WDU_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic fs_clk_i,
    input wire wdu_pkg::wdu_mode_t mode_i,
    output logic wd_reset_req_o,
    output logic wd_overflow_irq_o,
    output logic trap_area_en_o,
    output logic trap_action_sel_o
);
    import wdu_pkg::*;

    wdu_cfg_t cfg_r;
    wdu_stat_t stat;
    logic active_r;
    logic fs_sync;
    logic fs_prev_r;
    logic req;
    logic wr_lane;
    logic [7:0] word_idx;
    logic cfg_wr;
    logic cmd_wr;
    logic clear_cmd;
    logic halted;
    logic low_clock;
    logic tick;
    logic [4:0] exp_base;
    logic [4:0] tap;
    logic ovf;
    logic [WDU_BIN_W-1:0] bin_count;

    // bus decode; a request is taken once, in the cycle before ack
    always_comb begin
        word_idx = wb_adr_i[WDU_ADR_W-1:2];
        req = wb_cyc_i && wb_stb_i && !wb_ack_o;
        wr_lane = req && wb_we_i && wb_sel_i[0];
        cfg_wr = wr_lane && (word_idx == WDU_CFG_IDX);
        cmd_wr = wr_lane && (word_idx == WDU_CMD_IDX);
        clear_cmd = cmd_wr && (wb_dat_i[7:0] == WDU_CMD_CLEAR);
    end

    // single-cycle ack for every address, mapped or not
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req;
        end
    end

    // write-only registers read as zero; only status shows state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= '0;
        end else if (req && !wb_we_i) begin
            wb_dat_o <= (word_idx == WDU_STAT_IDX) ? 32'(stat) : '0;
        end
    end

    // configuration; reset selects reset-request action and enable
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_r <= WDU_CFG_RESET;
        end else if (cfg_wr) begin
            cfg_r <= wb_dat_i[WDU_CFG_W-1:0];
            // once interrupt is chosen it sticks until reset
            if (!cfg_r.overflow_action_sel) begin
                cfg_r.overflow_action_sel <= 1'b0;
            end
        end
    end

    // effective enable: set by enable bit, dropped only by disable code
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            active_r <= 1'b1;
        end else if (cfg_wr && wb_dat_i[3]) begin
            active_r <= 1'b1;
        end else if (cmd_wr && (wb_dat_i[7:0] == WDU_CMD_DISABLE)
                     && !cfg_r.wd_enable_bit) begin
            active_r <= 1'b0;
        end
    end

    // trap area setting only latched by its own code; others ignored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trap_area_en_o <= WDU_CFG_RESET.ram_trap_enable;
            trap_action_sel_o <= WDU_CFG_RESET.trap_action_sel;
        end else begin
            trap_action_sel_o <= cfg_r.trap_action_sel;
            if (cmd_wr && (wb_dat_i[7:0] == WDU_CMD_TRAP)) begin
                trap_area_en_o <= cfg_r.ram_trap_enable;
            end
        end
    end

    // slow clock pin is synchronised before edge detection
    wdu_sync u_fs_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(fs_clk_i),
        .q_o(fs_sync)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fs_prev_r <= 1'b0;
        end else begin
            fs_prev_r <= fs_sync;
        end
    end

    // tick source and period tap; stop, idle and sleep modes stop ticks
    always_comb begin
        halted = mode_i.stop_mode || mode_i.idle_mode || mode_i.sleep_mode;
        low_clock = mode_i.slow_mode || mode_i.divider_clock_sel;
        tick = !halted && (low_clock ? (fs_sync && !fs_prev_r) : 1'b1);
        exp_base = low_clock ? WDU_FS_EXP0 : WDU_FC_EXP0;
        tap = exp_base - WDU_EXP_STEP * {3'h0, cfg_r.detect_time_sel} - WDU_TAP_OFS;
    end

    wdu_counter u_counter (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(tick),
        .clear_i(clear_cmd),
        .run_i(active_r),
        .tap_i(tap),
        .ovf_o(ovf),
        .bin_o(bin_count)
    );

    // overflow action; interrupt is never masked here
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wd_reset_req_o <= 1'b0;
            wd_overflow_irq_o <= 1'b0;
        end else begin
            wd_reset_req_o <= ovf && cfg_r.overflow_action_sel;
            wd_overflow_irq_o <= ovf && !cfg_r.overflow_action_sel;
        end
    end

    // status snapshot for software
    always_comb begin
        stat.bin_count = bin_count;
        stat.halted = halted;
        stat.low_clock = low_clock;
        stat.trap_area_en = trap_area_en_o;
        stat.active = active_r;
        stat.cfg = cfg_r;
    end
endmodule : wdu_top
`default_nettype wire

// ### dv/wdu_checker.sv
// port assertions for the watchdog unit
// assumes a bind onto wdu_top, one clock
`timescale 1ns/1ps
`default_nettype none
module wdu_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [wdu_pkg::WDU_ADR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire wdu_pkg::wdu_mode_t mode_i,
    input wire logic wd_reset_req_o,
    input wire logic wd_overflow_irq_o,
    input wire logic trap_area_en_o,
    input wire logic trap_action_sel_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic take;
    // request taken this edge
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    a_ack_next: assert property (take |=> wb_ack_o) else $error("ack late");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
    a_cfg_reads_zero: assert property (take && !wb_we_i && wb_adr_i[9:2] == 8'h34
        |=> wb_dat_o == 32'h0) else $error("config read");
    a_req_pulse: assert property (wd_reset_req_o |=> !wd_reset_req_o)
        else $error("req long");
    a_irq_pulse: assert property (wd_overflow_irq_o |=> !wd_overflow_irq_o)
        else $error("irq long");
    a_one_action: assert property (!(wd_reset_req_o && wd_overflow_irq_o))
        else $error("both actions");
    a_halt_quiet: assert property (mode_i.stop_mode [*2]
        |-> !(wd_reset_req_o || wd_overflow_irq_o)) else $error("halt ovf");
    a_trap_reset: assert property ($fell(rst_i) |-> trap_area_en_o && trap_action_sel_o)
        else $error("trap reset");
    // main scenarios reached
    c_req: cover property (wd_reset_req_o);
    c_irq: cover property (wd_overflow_irq_o);
    c_wr: cover property (take && wb_we_i);
endmodule : wdu_checker
bind wdu_top wdu_checker chk (.*);
`default_nettype wire

// ### dv/tb_top.sv
// register level test of the watchdog unit
// assumes the slow clock pin runs at a quarter of clk_i
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import wdu_pkg::*;
    logic clk_i, rst_i, cyc, stb, we, fs, ack, req, irq, tae, tas;
    logic [9:0] adr;
    logic [3:0] sel;
    logic [31:0] dat, rdat, q;
    wdu_mode_t mode;
    int num_errors = 0, num_checks = 0, ncyc = 0, nreq = 0, nirq = 0;
    wdu_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .fs_clk_i(fs), .mode_i(mode), .wd_reset_req_o(req),
        .wd_overflow_irq_o(irq), .trap_area_en_o(tae), .trap_action_sel_o(tas));
    // 20 MHz clock, slow clock off phase
    initial begin
        clk_i = 0;
        forever #25 clk_i = ~clk_i;
    end
    initial begin
        fs = 0;
        #13;
        forever #100 fs = ~fs;
    end
    // pulse tallies and hang limit
    always @(posedge clk_i) begin
        nreq <= nreq + (req === 1'h1);
        nirq <= nirq + (irq === 1'h1);
        ncyc <= ncyc + 1;
        if (ncyc > 80000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one classic cycle; held until ack is sampled
    task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {cyc, stb, we, adr, dat} <= {2'h3, w, a, d};
        @(posedge clk_i);
        while (ack !== 1'h1) @(posedge clk_i);
        q = rdat;
        {cyc, stb} <= 2'h0;
    endtask : bus
    task automatic stat(input logic [9:0] e);
        bus(1'h0, 10'h0D8, 32'h0);
        chk(q[9:0], e);
    endtask : stat
    // wait for an overflow pulse; its delay must fall in [lo,hi)
    task automatic waitp(input int lo, input int hi, input logic i);
        int n;
        n = 0;
        @(posedge clk_i);
        while ((i ? irq : req) !== 1'h1 && n < hi) begin
            @(posedge clk_i);
            n++;
        end
        chk(n >= lo && n < hi, 32'h1);
    endtask : waitp
    task automatic tally_and_finish();
        $display("errors %0d checks %0d", num_errors, num_checks);
        if (num_errors == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish
    // slow period is 2^11 ticks of 4 clocks
    initial begin
        {cyc, stb, we, adr, dat, mode} <= '0;
        rst_i <= 1'h1;
        sel <= 4'hF;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'h0;
        stat(10'h0F9);
        bus(1'h0, 10'h0D0, 32'h0);
        chk(q, 32'h0);
        bus(1'h0, 10'h3FC, 32'h0);
        chk(q, 32'h0);
        mode.divider_clock_sel <= 1'h1;
        bus(1'h1, 10'h0D0, 32'h3F);
        bus(1'h1, 10'h0D4, 32'h55);
        stat(10'h1FF);
        bus(1'h1, 10'h0D4, 32'h4E);
        waitp(6140, 8250, 1'h0);
        chk(nirq, 32'h0);
        bus(1'h1, 10'h0D4, 32'h4E);
        mode.stop_mode <= 1'h1;
        stat(10'h3FF);
        repeat (9000) @(posedge clk_i);
        chk(nreq, 32'h1);
        mode.stop_mode <= 1'h0;
        bus(1'h1, 10'h0D4, 32'h4E);
        waitp(6000, 8250, 1'h0);
        bus(1'h1, 10'h0D0, 32'h3E);
        bus(1'h1, 10'h0D0, 32'h3F);
        stat(10'h1FE);
        waitp(1, 8250, 1'h1);
        waitp(8185, 8200, 1'h1);
        chk(nreq, 32'h2);
        // one binary step done; idle then sleep must hold it, slow mode keeps low clock
        repeat (3000) @(posedge clk_i);
        stat(10'h1FE);
        chk(q[11:10], 32'h1);
        mode.idle_mode <= 1'h1;
        repeat (3000) @(posedge clk_i);
        stat(10'h3FE);
        chk(q[11:10], 32'h1);
        mode <= 5'h06;
        repeat (500) @(posedge clk_i);
        stat(10'h3FE);
        chk(q[11:10], 32'h1);
        mode.sleep_mode <= 1'h0;
        bus(1'h1, 10'h0D4, 32'hB1);
        stat(10'h1FE);
        bus(1'h1, 10'h0D4, 32'h4E);
        bus(1'h1, 10'h0D0, 32'h36);
        stat(10'h1F6);
        bus(1'h1, 10'h0D4, 32'hB1);
        stat(10'h1B6);
        chk(q[11:10], 32'h0);
        repeat (9000) @(posedge clk_i);
        chk(nirq, 32'h2);
        stat(10'h1B6);
        chk(q[11:10], 32'h0);
        // trap area bit moves only on its own code; action bit follows config
        bus(1'h1, 10'h0D0, 32'h06);
        stat(10'h186);
        chk({tae, tas}, 32'h2);
        bus(1'h1, 10'h0D4, 32'hD2);
        stat(10'h106);
        chk({tae, tas}, 32'h0);
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
